// ---- hw/vic_top.sv ----
`timescale 1ns/10ps
// How it works
// - each request gets vector n+8, table address
// - equal priority ties go to lowest number
// - flag/enable word n/16, priority word n/4
// - events set flags until software clears
// - only enabled flags may interrupt
// - each source has three-bit priority field
// - latch vector number and level when presenting
// - reset clears everything except global enable in control two, controller not involved
// - control one holds nesting off, trap flags
// - control two holds global enable, edge polarity
// - control three holds deadman, dma, loop traps
// - control four holds double-error, software trap
// - flash single-bit error is request 186
// - waveform generator events are requests 94-96
// - core level seven blocks all user requests
// - nesting off blocks preemption while in service
module vic_top
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic                     CLOCK,
  input  wire logic                     NRST,
  // register bus
  input  wire logic                     AWVALID,
  output logic                          AWREADY,
  input  wire logic [vic_pkg::VIC_AW-1:0] AWADDR,
  input  wire logic                     WVALID,
  output logic                          WREADY,
  input  wire logic [31:0]              WDATA,
  input  wire logic [3:0]               WSTRB,
  output logic                          BVALID,
  input  wire logic                     BREADY,
  output logic [1:0]                    BRESP,
  input  wire logic                     ARVALID,
  output logic                          ARREADY,
  input  wire logic [vic_pkg::VIC_AW-1:0] ARADDR,
  output logic                          RVALID,
  input  wire logic                     RREADY,
  output logic [31:0]                   RDATA,
  output logic [1:0]                    RRESP,
  // event sources
  input  wire logic [vic_pkg::VIC_NSRC-1:0] PERIPH_EVENT,
  input  wire logic [2:0]               EXT_REQ_PIN,
  input  wire logic [6:0]               CORE_TRAP_EVENT,
  input  wire logic [2:0]               SOFT_TRAP_EVENT,
  input  wire logic [1:0]               HARD_TRAP_EVENT,
  // core side
  input  wire logic [3:0]               CPU_PRIORITY_LEVEL,
  input  wire logic                     CPU_IN_SERVICE,
  output logic                          CPU_IRQ_REQ,
  output logic [7:0]                    CPU_IRQ_VECTOR,
  output logic [3:0]                    CPU_IRQ_LEVEL,
  output logic [23:0]                   CPU_IRQ_ADDR,
  // system interrupt
  output logic                          IRQ
);
  import vic_pkg::*;

  typedef struct packed {
    logic [VIC_NFLAG-1:0][15:0] flag;
    logic [VIC_NFLAG-1:0][15:0] en;
    logic [VIC_NPRIO-1:0][15:0] prio;
    logic [15:0]                gc1;
    logic [15:0]                gc2;
    logic [15:0]                gc3;
    logic [15:0]                gc4;
    logic [7:0]                 vec_num;
    logic [3:0]                 vec_lvl;
    logic [23:0]                vec_addr;
    logic                       irq_req;
    logic [1:0]                 sts;
    logic [1:0]                 msk;
    logic [2:0]                 ext_s1;
    logic [2:0]                 ext_s2;
    logic [2:0]                 ext_prev;
    logic                       aw_got;
    logic                       w_got;
    logic [VIC_AW-1:0]          awaddr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } vic_state_t;

  vic_state_t s_q;
  vic_state_t s_d;

  logic [VIC_NSRC-1:0]      req_v;
  logic [VIC_NSRC-1:0][2:0] prio_v;
  logic                     win_valid;
  logic [7:0]               win_idx;
  logic [2:0]               win_lvl;
  logic                     present;
  logic [2:0]               ext_edge;

  // byte-lane merge of a 16-bit register, restricted to writable bits
  function automatic logic [15:0] vic_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb, input logic [15:0] wm);
    logic [15:0] nv;
    nv = old;
    if (strb[0]) begin
      nv[7:0] = d[7:0];
    end
    if (strb[1]) begin
      nv[15:8] = d[15:8];
    end
    return (nv & wm) | (old & ~wm);
  endfunction : vic_merge

  // register read decode; bit 16 flags a mapped address
  function automatic logic [16:0] vic_read(input vic_state_t s, input logic [VIC_AW-1:0] a);
    logic [16:0] r;
    r = 17'h00000;
    if (a >= VIC_OFF_FLAG && a < VIC_OFF_FLAG + 12'(4 * VIC_NFLAG)) begin
      r = {1'b1, s.flag[4'((a - VIC_OFF_FLAG) >> 2)]};
    end else if (a >= VIC_OFF_EN && a < VIC_OFF_EN + 12'(4 * VIC_NFLAG)) begin
      r = {1'b1, s.en[4'((a - VIC_OFF_EN) >> 2)]};
    end else if (a >= VIC_OFF_PRIO && a < VIC_OFF_PRIO + 12'(4 * VIC_NPRIO)) begin
      r = {1'b1, s.prio[6'((a - VIC_OFF_PRIO) >> 2)]};
    end else begin
      case (a)
        VIC_OFF_GC1: r = {1'b1, s.gc1};
        VIC_OFF_GC2: r = {1'b1, s.gc2};
        VIC_OFF_GC3: r = {1'b1, s.gc3};
        VIC_OFF_GC4: r = {1'b1, s.gc4};
        VIC_OFF_PVEC: r = {1'b1, 4'h0, s.vec_lvl, s.vec_num};
        VIC_OFF_STS: r = {1'b1, 14'h0000, s.sts};
        VIC_OFF_MSK: r = {1'b1, 14'h0000, s.msk};
        default: r = 17'h00000;
      endcase
    end
    return r;
  endfunction : vic_read

  // word n/16 bit n%16, field at 4*(n%4)
  always_comb begin
    req_v  = VIC_NSRC'(s_q.flag & s_q.en);
    prio_v = '0;
    for (int i = 0; i < VIC_NSRC; i++) begin
      prio_v[i] = s_q.prio[i / 4][4 * (i % 4) +: 3];
    end
  end

  // lowest number wins among equal levels
  vic_arbiter #(
    .N (VIC_NSRC)
  ) u_arb (
    .req   (req_v),
    .prio  (prio_v),
    .valid (win_valid),
    .idx   (win_idx),
    .lvl   (win_lvl)
  );

  // req_v already gates flags with enables
  // strictly above core level, global enable set
  // level seven shuts out user requests
  // no preemption while nesting is off
  assign present = win_valid
                   && s_q.gc2[VIC_GIE_BIT]
                   && CPU_PRIORITY_LEVEL < VIC_IPL_USER_OFF
                   && {1'b0, win_lvl} > CPU_PRIORITY_LEVEL
                   && !(s_q.gc1[VIC_NESTING_DISABLE_BIT] && CPU_IN_SERVICE);

  // polarity bit 0 is rising edge, 1 falling
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      ext_edge[k] = s_q.gc2[k] ? (s_q.ext_prev[k] && !s_q.ext_s2[k])
                               : (!s_q.ext_prev[k] && s_q.ext_s2[k]);
    end
  end

  always_comb begin
    logic [VIC_NFLAG*16-1:0] set_v;
    logic [16:0]             rd;
    logic [VIC_AW-1:0]       wa;
    logic                    whit;
    logic                    trap_any;
    set_v    = '0;
    rd       = 17'h00000;
    wa       = s_q.awaddr;
    whit     = 1'b0;
    trap_any = 1'b0;
    s_d      = s_q;

    // pin synchronisers; edges compare the second stage with ext_prev
    s_d.ext_s1   = EXT_REQ_PIN;
    s_d.ext_s2   = s_q.ext_s1;
    s_d.ext_prev = s_q.ext_s2;

    // bus handshakes
    if (AWVALID && AWREADY) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = AWADDR;
    end
    if (WVALID && WREADY) begin
      s_d.w_got = 1'b1;
      s_d.wdata = WDATA;
      s_d.wstrb = WSTRB;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rd          = vic_read(s_q, ARADDR);
      s_d.rvalid  = 1'b1;
      s_d.rdata   = {16'h0000, rd[15:0]};
      s_d.rresp   = rd[16] ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end

    // register write once address and data are both held
    if (s_q.aw_got && s_q.w_got) begin
      whit = vic_read(s_q, wa) >> 16 != 17'h0;
      if (wa >= VIC_OFF_FLAG && wa < VIC_OFF_FLAG + 12'(4 * VIC_NFLAG)) begin
        s_d.flag[4'((wa - VIC_OFF_FLAG) >> 2)] =
          vic_merge(s_q.flag[4'((wa - VIC_OFF_FLAG) >> 2)], s_q.wdata, s_q.wstrb, 16'hffff);
      end else if (wa >= VIC_OFF_EN && wa < VIC_OFF_EN + 12'(4 * VIC_NFLAG)) begin
        s_d.en[4'((wa - VIC_OFF_EN) >> 2)] =
          vic_merge(s_q.en[4'((wa - VIC_OFF_EN) >> 2)], s_q.wdata, s_q.wstrb, 16'hffff);
      end else if (wa >= VIC_OFF_PRIO && wa < VIC_OFF_PRIO + 12'(4 * VIC_NPRIO)) begin
        s_d.prio[6'((wa - VIC_OFF_PRIO) >> 2)] =
          vic_merge(s_q.prio[6'((wa - VIC_OFF_PRIO) >> 2)], s_q.wdata, s_q.wstrb,
                    VIC_PRIO_WMASK);
      end else begin
        case (wa)
          VIC_OFF_GC1: s_d.gc1 = vic_merge(s_q.gc1, s_q.wdata, s_q.wstrb, VIC_GC1_WMASK);
          VIC_OFF_GC2: s_d.gc2 = vic_merge(s_q.gc2, s_q.wdata, s_q.wstrb, VIC_GC2_WMASK);
          VIC_OFF_GC3: s_d.gc3 = vic_merge(s_q.gc3, s_q.wdata, s_q.wstrb, VIC_GC3_WMASK);
          VIC_OFF_GC4: s_d.gc4 = vic_merge(s_q.gc4, s_q.wdata, s_q.wstrb, VIC_GC4_WMASK);
          VIC_OFF_STS: begin
            if (s_q.wstrb[0]) begin
              s_d.sts = s_q.sts & ~s_q.wdata[1:0];
            end
          end
          VIC_OFF_MSK: begin
            if (s_q.wstrb[0]) begin
              s_d.msk = s_q.wdata[1:0];
            end
          end
          default: s_d.sts = s_q.sts;
        endcase
      end
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = whit ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end

    // hardware sets after software writes, so set wins
    // flash single-bit error arrives on event 186
    // waveform events arrive on 94, 95 and 96
    set_v[VIC_NSRC-1:0]    = PERIPH_EVENT;
    set_v[VIC_SRC_EXT0]    = set_v[VIC_SRC_EXT0] | ext_edge[0];
    set_v[VIC_SRC_EXT1]    = set_v[VIC_SRC_EXT1] | ext_edge[1];
    set_v[VIC_SRC_EXT2]    = set_v[VIC_SRC_EXT2] | ext_edge[2];
    s_d.flag               = s_d.flag | set_v;

    // core trap flags land in control one
    s_d.gc1 = s_d.gc1 | {8'h00, CORE_TRAP_EVENT, 1'b0};
    s_d.gc3 = s_d.gc3 | {SOFT_TRAP_EVENT[2], 9'h000, SOFT_TRAP_EVENT[1:0], 4'h0};
    // double-bit error and software hard trap
    s_d.gc4 = s_d.gc4 | {14'h0000, HARD_TRAP_EVENT};
    trap_any = |{CORE_TRAP_EVENT, SOFT_TRAP_EVENT, HARD_TRAP_EVENT};

    // vector and level latched while presenting
    // vector n+8 at table base plus 2n
    s_d.irq_req = present;
    if (present) begin
      s_d.vec_num  = VIC_VEC_FIRST + win_idx;
      s_d.vec_lvl  = {1'b0, win_lvl};
      s_d.vec_addr = VIC_IVT_FIRST + {15'h0000, win_idx, 1'b0};
    end

    // sticky status after any clear so a new event survives
    if (present && !s_q.irq_req) begin
      s_d.sts[VIC_STS_VEC] = 1'b1;
    end
    if (trap_any) begin
      s_d.sts[VIC_STS_TRAP] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      // plain clear, no vector fetch involved
      s_q     <= '0;
      s_q.gc1 <= VIC_GC1_RST;
      s_q.gc2 <= VIC_GC2_RST;
      s_q.gc3 <= VIC_GC3_RST;
      s_q.gc4 <= VIC_GC4_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // hold off new requests while an answer waits to be taken
  assign AWREADY        = !s_q.aw_got && !s_q.bvalid;
  assign WREADY         = !s_q.w_got && !s_q.bvalid;
  assign BVALID         = s_q.bvalid;
  assign BRESP          = s_q.bresp;
  assign ARREADY        = !s_q.rvalid;
  assign RVALID         = s_q.rvalid;
  assign RDATA          = s_q.rdata;
  assign RRESP          = s_q.rresp;
  assign CPU_IRQ_REQ    = s_q.irq_req;
  assign CPU_IRQ_VECTOR = s_q.vec_num;
  assign CPU_IRQ_LEVEL  = s_q.vec_lvl;
  assign CPU_IRQ_ADDR   = s_q.vec_addr;
  assign IRQ            = |(s_q.sts & s_q.msk);
endmodule : vic_top

// ---- include/vic_pkg.sv ----
package vic_pkg;
  // source population and register counts
  localparam int          VIC_NSRC       = 187;
  localparam int          VIC_NFLAG      = 12;
  localparam int          VIC_NPRIO      = 47;
  localparam int          VIC_AW         = 12;
  // byte offsets on the register bus
  localparam logic [11:0] VIC_OFF_FLAG   = 12'h000;
  localparam logic [11:0] VIC_OFF_EN     = 12'h040;
  localparam logic [11:0] VIC_OFF_GC1    = 12'h080;
  localparam logic [11:0] VIC_OFF_GC2    = 12'h084;
  localparam logic [11:0] VIC_OFF_GC3    = 12'h088;
  localparam logic [11:0] VIC_OFF_GC4    = 12'h08c;
  localparam logic [11:0] VIC_OFF_PVEC   = 12'h090;
  localparam logic [11:0] VIC_OFF_STS    = 12'h094;
  localparam logic [11:0] VIC_OFF_MSK    = 12'h098;
  localparam logic [11:0] VIC_OFF_PRIO   = 12'h100;
  // vector numbering and table placement
  localparam logic [7:0]  VIC_VEC_FIRST  = 8'h08;
  localparam logic [23:0] VIC_IVT_FIRST  = 24'h000014;
  // field positions
  localparam int          VIC_NESTING_DISABLE_BIT = 15;
  localparam int          VIC_GIE_BIT    = 15;
  localparam int          VIC_GC1_TRAP_LSB = 1;
  localparam int          VIC_SRC_EXT0   = 0;
  localparam int          VIC_SRC_EXT1   = 20;
  localparam int          VIC_SRC_EXT2   = 29;
  localparam int          VIC_STS_VEC    = 0;
  localparam int          VIC_STS_TRAP   = 1;
  // values after reset and writable masks
  localparam logic [15:0] VIC_GC1_RST    = 16'h0000;
  localparam logic [15:0] VIC_GC2_RST    = 16'h8000;
  localparam logic [15:0] VIC_GC3_RST    = 16'h0000;
  localparam logic [15:0] VIC_GC4_RST    = 16'h0000;
  localparam logic [15:0] VIC_GC1_WMASK  = 16'hfffe;
  localparam logic [15:0] VIC_GC2_WMASK  = 16'he107;
  localparam logic [15:0] VIC_GC3_WMASK  = 16'h8030;
  localparam logic [15:0] VIC_GC4_WMASK  = 16'h0003;
  localparam logic [15:0] VIC_PRIO_WMASK = 16'h7777;
  localparam logic [3:0]  VIC_IPL_USER_OFF = 4'h7;
  // bus answers
  localparam logic [1:0]  VIC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  VIC_RESP_SLVERR = 2'h2;
endpackage : vic_pkg

// ---- hw/vic_arbiter.sv ----
`timescale 1ns/10ps
module vic_arbiter #(
  parameter int N = 187
) (
  // pending sources
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0][2:0] prio,
  // winner
  output logic                   valid,
  output logic [7:0]             idx,
  output logic [2:0]             lvl
);
  // scan downward with >= so the lowest number wins a tie
  always_comb begin
    valid = 1'b0;
    idx   = 8'h00;
    lvl   = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!valid || prio[i] >= lvl)) begin
        valid = 1'b1;
        idx   = 8'(i);
        lvl   = prio[i];
      end
    end
  end
endmodule : vic_arbiter

// ---- bench/vic_props.sv ----
`timescale 1ns/10ps
module vic_props
  import vic_pkg::*;
(
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        NRST,
  // register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // core side
  input wire logic [3:0]  CPU_PRIORITY_LEVEL,
  input wire logic        CPU_IRQ_REQ,
  input wire logic [7:0]  CPU_IRQ_VECTOR,
  input wire logic [3:0]  CPU_IRQ_LEVEL,
  input wire logic [23:0] CPU_IRQ_ADDR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_taken;
    ARVALID && ARREADY;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] BVALID)
    else $error("write not answered");
  a_read_answer: assert property (rd_taken |=> RVALID)
    else $error("read not answered");
  a_bresp_release: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write answer kept");
  a_rdata_release: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read answer kept");
  a_no_new_write: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answering");
  a_no_new_read: assert property (RVALID |-> !ARREADY)
    else $error("read taken while answering");
  a_addr_from_vec: assert property (CPU_IRQ_REQ |->
    CPU_IRQ_ADDR == VIC_IVT_FIRST + {15'h0, CPU_IRQ_VECTOR - VIC_VEC_FIRST, 1'b0})
    else $error("table address wrong");
  a_vec_in_table: assert property (CPU_IRQ_REQ |-> CPU_IRQ_VECTOR inside {[8'h08:8'hc2]})
    else $error("vector out of table");
  a_above_core: assert property (CPU_IRQ_REQ |->
    CPU_IRQ_LEVEL > $past(CPU_PRIORITY_LEVEL) && !CPU_IRQ_LEVEL[3])
    else $error("request not above core level");
  a_seven_blocks: assert property ($past(CPU_PRIORITY_LEVEL) >= 4'h7 |-> !CPU_IRQ_REQ)
    else $error("request at core level seven");
endmodule : vic_props

bind vic_top vic_props u_props (.*);

// ---- bench/vic_core_model.sv ----
`timescale 1ns/10ps
module vic_core_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // controller request
  input wire logic       req,
  input wire logic [3:0] new_lvl,
  // bench control
  input wire logic [3:0] base_lvl,
  input wire logic       take,
  input wire logic       done,
  // core state
  output logic [3:0]     cpu_lvl,
  output logic           in_svc
);
  typedef struct packed {logic svc; logic [3:0] lvl;} vic_core_t;
  vic_core_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (done)
      st_d.svc = 1'b0;
    else if (take && req && !st_q.svc)
      st_d = '{svc: 1'b1, lvl: new_lvl};
  end
  always_ff @(posedge clk) begin
    st_q <= nrst ? st_d : '0;
  end
  assign cpu_lvl = st_q.svc ? st_q.lvl : base_lvl;
  assign in_svc  = st_q.svc;
endmodule : vic_core_model

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import vic_pkg::*;
  typedef struct {int src; logic [2:0] pr; logic [7:0] vec; logic [23:0] adr;} vic_row_t;
  vic_row_t rows [6] = '{'{0, 3'h1, 8'h08, 24'h14}, '{5, 3'h3, 8'h0d, 24'h1e},
    '{94, 3'h7, 8'h66, 24'hd0}, '{95, 3'h4, 8'h67, 24'hd2},
    '{96, 3'h2, 8'h68, 24'hd4}, '{186, 3'h6, 8'hc2, 24'h188}};
  logic         CLOCK, NRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic         ARVALID, ARREADY, RVALID, RREADY, CPU_IN_SERVICE, CPU_IRQ_REQ, IRQ, take, done;
  logic [11:0]  AWADDR, ARADDR, fa;
  logic [31:0]  WDATA, RDATA, rdat;
  logic [3:0]   WSTRB, CPU_PRIORITY_LEVEL, CPU_IRQ_LEVEL, base;
  logic [1:0]   BRESP, RRESP, HARD_TRAP_EVENT, rresp, wresp;
  logic [186:0] PERIPH_EVENT;
  logic [2:0]   EXT_REQ_PIN, SOFT_TRAP_EVENT;
  logic [6:0]   CORE_TRAP_EVENT;
  logic [7:0]   CPU_IRQ_VECTOR;
  logic [23:0]  CPU_IRQ_ADDR;
  int           num_errors, comparisons, n;
  vic_top dut (.*);
  vic_core_model core (.clk(CLOCK), .nrst(NRST), .req(CPU_IRQ_REQ), .new_lvl(CPU_IRQ_LEVEL),
    .base_lvl(base), .take(take), .done(done), .cpu_lvl(CPU_PRIORITY_LEVEL),
    .in_svc(CPU_IN_SERVICE));
  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic tmo(input string what);
    chk(what, 32'h1, 32'h0);
    end_of_test;
  endtask : tmo
  // readys sampled mid-cycle: reading them at the edge races the update
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    logic aw_t, w_t, b_t;
    @(posedge CLOCK);
    {AWADDR, WDATA} <= {a, d};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    i = 0;
    do begin
      @(negedge CLOCK);
      aw_t = AWVALID && AWREADY;
      w_t = WVALID && WREADY;
      b_t = (BVALID === 1'b1);
      wresp = BRESP;
      @(posedge CLOCK);
      if (aw_t) AWVALID <= 1'b0;
      if (w_t) WVALID <= 1'b0;
      i++;
    end while (!b_t && i < 64);
    BREADY <= 1'b0;
    if (i >= 64) tmo("write wait");
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int i;
    logic ar_t, r_t;
    @(posedge CLOCK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    i = 0;
    do begin
      @(negedge CLOCK);
      ar_t = ARVALID && ARREADY;
      r_t = (RVALID === 1'b1);
      {rdat, rresp} = {RDATA, RRESP};
      @(posedge CLOCK);
      if (ar_t) ARVALID <= 1'b0;
      i++;
    end while (!r_t && i < 64);
    RREADY <= 1'b0;
    if (i >= 64) tmo("read wait");
  endtask : rd
  task automatic rc(input string what, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(what, e, rdat);
  endtask : rc
  task automatic pulse(input logic [186:0] m);
    @(posedge CLOCK);
    PERIPH_EVENT <= m;
    @(posedge CLOCK);
    PERIPH_EVENT <= '0;
  endtask : pulse
  task automatic wreq(input logic v);
    int i;
    i = 0;
    while (CPU_IRQ_REQ !== v && i < 32) begin
      @(posedge CLOCK);
      #1;
      i++;
    end
    if (i >= 32) tmo("request wait");
  endtask : wreq
  // request lands two cycles after its cause, so six quiet cycles suffice
  task automatic quiet(input string what);
    repeat (6) @(posedge CLOCK);
    #1;
    chk(what, 32'h0, {31'h0, CPU_IRQ_REQ});
  endtask : quiet
  initial begin
    repeat (20000) @(posedge CLOCK);
    tmo("run time");
  end
  initial begin
    {NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, take, done} = '0;
    {AWADDR, ARADDR, WDATA, PERIPH_EVENT, EXT_REQ_PIN} = '0;
    {SOFT_TRAP_EVENT, HARD_TRAP_EVENT, CORE_TRAP_EVENT, base} = '0;
    WSTRB = 4'hf;
    {num_errors, comparisons} = '0;
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    rc("control two", VIC_OFF_GC2, 32'h8000);
    rc("control one", VIC_OFF_GC1, 32'h0);
    rd(12'hffc);
    chk("unmapped resp", {30'h0, VIC_RESP_SLVERR}, {30'h0, rresp});
    wr(12'hffc, 32'h0);
    chk("unmapped wresp", {30'h0, VIC_RESP_SLVERR}, {30'h0, wresp});
    wr(VIC_OFF_GC4, 32'h0);
    chk("mapped wresp", {30'h0, VIC_RESP_OKAY}, {30'h0, wresp});
    $display("test reset done");
    foreach (rows[k]) begin
      n = rows[k].src;
      fa = 12'(4 * (n / 16));
      wr(VIC_OFF_PRIO + 12'(4 * (n / 4)), 32'(rows[k].pr) << (4 * (n % 4)));
      wr(VIC_OFF_EN + fa, 32'h1 << (n % 16));
      pulse(187'(1) << n);
      wreq(1'b1);
      chk("vector", 32'(rows[k].vec), 32'(CPU_IRQ_VECTOR));
      chk("level", 32'(rows[k].pr), 32'(CPU_IRQ_LEVEL));
      chk("address", 32'(rows[k].adr), 32'(CPU_IRQ_ADDR));
      rc("flag", VIC_OFF_FLAG + fa, 32'h1 << (n % 16));
      rc("pending", VIC_OFF_PVEC, {20'h0, 1'b0, rows[k].pr, rows[k].vec});
      wr(VIC_OFF_FLAG + fa, 32'h0);
      wr(VIC_OFF_EN + fa, 32'h0);
      wreq(1'b0);
      $display("test source %0d done", n);
    end
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(VIC_OFF_MSK, 32'h1);
    @(negedge CLOCK);
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(VIC_OFF_STS, 32'h1);
    @(negedge CLOCK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    $display("test interrupt done");
    wr(VIC_OFF_PRIO, 32'h2000);
    wr(VIC_OFF_PRIO + 12'h4, 32'h0200);
    wr(VIC_OFF_EN, 32'h48);
    pulse(187'h48);
    wreq(1'b1);
    chk("tie vector", 32'h0b, 32'(CPU_IRQ_VECTOR));
    wr(VIC_OFF_GC1, 32'h8000);
    take <= 1'b1;
    @(posedge CLOCK);
    take <= 1'b0;
    wr(VIC_OFF_PRIO + 12'h4, 32'h0500);
    quiet("nested request");
    wr(VIC_OFF_GC1, 32'h0);
    wreq(1'b1);
    chk("preempt vector", 32'h0e, 32'(CPU_IRQ_VECTOR));
    {done, base} <= {1'b1, 4'h7};
    @(posedge CLOCK);
    done <= 1'b0;
    quiet("level seven");
    base <= 4'h0;
    wreq(1'b1);
    wr(VIC_OFF_GC2, 32'h0);
    quiet("global off");
    wr(VIC_OFF_GC2, 32'h8000);
    wreq(1'b1);
    wr(VIC_OFF_EN, 32'h0);
    quiet("enable off");
    wr(VIC_OFF_PRIO, 32'h2001);
    wr(VIC_OFF_EN, 32'h1);
    EXT_REQ_PIN <= 3'h1;
    wreq(1'b1);
    chk("pin vector", 32'h08, 32'(CPU_IRQ_VECTOR));
    EXT_REQ_PIN <= 3'h0;
    wr(VIC_OFF_EN, 32'h0);
    wr(VIC_OFF_FLAG, 32'h0);
    quiet("pin cleared");
    $display("test arbitration done");
    {SOFT_TRAP_EVENT, HARD_TRAP_EVENT, CORE_TRAP_EVENT} <= '1;
    @(posedge CLOCK);
    {SOFT_TRAP_EVENT, HARD_TRAP_EVENT, CORE_TRAP_EVENT} <= '0;
    rc("control three", VIC_OFF_GC3, 32'h8030);
    rc("control four", VIC_OFF_GC4, 32'h0003);
    rc("control one", VIC_OFF_GC1, 32'h00fe);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    rc("flag after reset", VIC_OFF_FLAG, 32'h0);
    $display("test traps done");
    end_of_test;
  end
endmodule : testbench
